// ===== rtl/fifo_offset_host.sv
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/100ps
module fifo_offset_host #(
   parameter int BUS_W = 36,
   parameter int OUT_W = 36,
   parameter int OFS_W = 18
) (
   // clock and reset
   input  wire logic                          mclk,
   input  wire logic                          rst,
   // command port
   input  wire logic [fofs_pkg::ADDR_W-1:0]   addr,
   input  wire logic [fofs_pkg::REG_W-1:0]    wdata,
   input  wire logic                          wr_en,
   input  wire logic                          rd_en,
   output logic      [fofs_pkg::REG_W-1:0]    rdata,
   // fifo pins
   output fofs_pkg::pins_t                    pins,
   output logic      [BUS_W-1:0]              write_data_in,
   input  wire logic [OUT_W-1:0]              read_data_out,
   input  wire logic                          almost_empty_flag_n,
   input  wire logic                          almost_full_flag_n
);
   import fofs_pkg::*;

   localparam int WW   = words_per_offset(BUS_W, OFS_W);
   localparam int RW   = words_per_offset(OUT_W, OFS_W);
   localparam int RBUF = 2 * RW * OUT_W;
   localparam int SW   = OUT_W + 2;

   if (!(BUS_W == 9 || BUS_W == 18 || BUS_W == 36) ||
       !(OUT_W == 9 || OUT_W == 18 || OUT_W == 36) ||
       OFS_W < 10 || OFS_W > 18 || LINK_HALF < 4) begin : g_bad
      $error("fifo_offset_host: unsupported parameters");
   end

   state_t              st, next_st, start_st;
   logic [PH_W-1:0]     ph, next_ph;
   logic [5:0]          cnt, next_cnt, limit;
   logic                step_end, start, cmd_ok, hi;
   logic                valid, next_valid;
   logic                serial_latched, next_serial;
   logic                mrs_done, next_mrs_done;
   logic [RBUF-1:0]     rbuf, next_rbuf;
   logic [1:0]          cfg, next_cfg;
   logic [OFS_W-1:0]    empty_ofs, next_empty, full_ofs, next_full;
   logic [REG_W-1:0]    next_rdata;
   logic [5:0]          status;
   pins_t               next_pins;
   logic [BUS_W-1:0]    next_wdata;
   logic [2*WW*BUS_W-1:0] wbuf;
   logic [2*OFS_W-1:0]  ser_bits;
   logic [SW-1:0]       s1, s2, s3, filt, next_filt;
   logic [5:0]          nsclk, next_nsclk, nwclk, next_nwclk;
   cmd_t                cmd;

   // pins pass three flops; a bit moves only once the last two agree
   always_comb begin
      next_filt = (s2 & s3) | (filt & (s2 | s3));
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s1   <= '0;
         s2   <= '0;
         s3   <= '0;
         filt <= '1;
      end else begin
         s1   <= {almost_full_flag_n, almost_empty_flag_n, read_data_out};
         s2   <= s1;
         s3   <= s2;
         filt <= next_filt;
      end
   end

   // command decode
   assign cmd      = cmd_t'(wdata[CTRL_CMD +: 2]);
   assign ser_bits = {full_ofs, empty_ofs};
   assign wbuf     = {(WW*BUS_W)'(full_ofs), (WW*BUS_W)'(empty_ofs)};

   always_comb begin
      start_st = S_RESET;
      cmd_ok   = 1'b1;
      unique case (cmd)
         CMD_MRESET: begin
            start_st = S_RESET;
         end
         CMD_SERIAL: begin
            start_st = S_SHIFT;
            cmd_ok   = mrs_done & serial_latched;
         end
         CMD_PARALLEL: begin
            start_st = S_WRITE;
            cmd_ok   = mrs_done & ~serial_latched;
         end
         CMD_READ: begin
            start_st = S_READ;
            cmd_ok   = mrs_done;
         end
      endcase
      start = wr_en && addr == A_CTRL && wdata[CTRL_GO] &&
              st == S_IDLE && cmd_ok;
   end

   // sequencer: one step is one link clock period, rising mid-step
   always_comb begin
      next_st       = st;
      next_ph       = '0;
      next_cnt      = cnt;
      next_valid    = valid;
      next_serial   = serial_latched;
      next_mrs_done = mrs_done;
      next_rbuf     = rbuf;
      step_end      = (ph == PH_W'(2 * LINK_HALF - 1));
      unique case (st)
         S_IDLE:   limit = 6'h01;
         S_RESET:  limit = 6'(MRS_STEPS);
         S_SHIFT:  limit = 6'(2 * OFS_W);
         S_WRITE:  limit = 6'(2 * WW);
         S_READ:   limit = 6'(4 * RW);
         S_SETTLE: limit = serial_latched ? 6'(SETTLE_SER)
                                          : 6'(SETTLE_PAR);
         default:  limit = 6'h01;
      endcase
      if (st == S_IDLE) begin
         next_cnt = '0;
         if (start) begin
            next_st = start_st;
            if (start_st == S_RESET) begin
               next_serial   = cfg[CFG_SERIAL];
               next_mrs_done = 1'b0;
            end
            if (start_st != S_READ)
               next_valid = 1'b0;
         end
      end else begin
         next_ph = step_end ? '0 : ph + 1'b1;
         // sample at the end of the quiet step: the pin filter lags the
         // read edge by four cycles, so the read step itself is too early
         if (st == S_READ && step_end && cnt[0])
            next_rbuf[int'(cnt[5:1]) * OUT_W +: OUT_W] =
               filt[OUT_W-1:0];
         if (step_end) begin
            next_cnt = cnt + 6'h01;
            if (cnt == limit - 6'h01) begin
               next_cnt = '0;
               next_st  = (st == S_SHIFT || st == S_WRITE) ? S_SETTLE
                                                           : S_IDLE;
               if (st == S_SETTLE)
                  next_valid = 1'b1;
               if (st == S_RESET)
                  next_mrs_done = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st             <= S_IDLE;
         ph             <= '0;
         cnt            <= '0;
         valid          <= 1'b0;
         serial_latched <= 1'b0;
         mrs_done       <= 1'b0;
         rbuf           <= '0;
      end else begin
         st             <= next_st;
         ph             <= next_ph;
         cnt            <= next_cnt;
         valid          <= next_valid;
         serial_latched <= next_serial;
         mrs_done       <= next_mrs_done;
         rbuf           <= next_rbuf;
      end
   end

   // pin drive; data moves while the link clock is low
   always_comb begin
      hi         = (next_ph >= PH_W'(LINK_HALF));
      next_pins  = PINS_IDLE;
      next_pins.serial_mode             = pins.serial_mode;
      next_pins.first_word_fall_through = pins.first_word_fall_through;
      next_wdata = write_data_in;
      unique case (next_st)
         S_IDLE: begin
         end
         S_RESET: begin
            next_pins.mrs_n       = 1'b0;
            next_pins.serial_mode = cfg[CFG_SERIAL];
            next_pins.first_word_fall_through = cfg[CFG_FIRST_WORD_FALL_THROUGH];
            next_pins.write_clock = hi;
            next_pins.read_clock  = hi;
         end
         S_SHIFT: begin
            next_pins.load_select_n   = 1'b0;
            next_pins.serial_enable_n = 1'b0;
            next_pins.serial_in       = ser_bits[next_cnt];
            next_pins.serial_clock    = hi;
         end
         S_WRITE: begin
            next_pins.load_select_n  = 1'b0;
            next_pins.write_enable_n = 1'b0;
            next_pins.write_clock    = hi;
            next_wdata = wbuf[int'(next_cnt) * BUS_W +: BUS_W];
         end
         S_READ: begin
            // odd steps keep reads off for a whole read clock
            next_pins.load_select_n = 1'b0;
            next_pins.read_enable_n = next_cnt[0];
            next_pins.read_clock    = hi;
         end
         S_SETTLE: begin
            next_pins.write_clock = hi;
            next_pins.read_clock  = hi;
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pins          <= PINS_IDLE;
         write_data_in <= '0;
      end else begin
         pins          <= next_pins;
         write_data_in <= next_wdata;
      end
   end

   // command registers
   always_comb begin
      status              = '0;
      status[ST_BUSY]     = (st != S_IDLE);
      status[ST_SERIAL]   = serial_latched;
      status[ST_MRS_DONE] = mrs_done;
      status[ST_VALID]    = valid;
      status[ST_AE]       = valid & ~filt[OUT_W];
      status[ST_AF]       = valid & ~filt[OUT_W+1];
      next_cfg   = cfg;
      next_empty = empty_ofs;
      next_full  = full_ofs;
      next_rdata = '0;
      if (wr_en && st == S_IDLE) begin
         // offsets may not change under a running sequence
         if (addr == A_CFG)   next_cfg   = wdata[1:0];
         if (addr == A_EMPTY) next_empty = wdata[OFS_W-1:0];
         if (addr == A_FULL)  next_full  = wdata[OFS_W-1:0];
      end
      if (rd_en) begin
         unique case (addr)
            A_CFG:      next_rdata = REG_W'(cfg);
            A_EMPTY:    next_rdata = REG_W'(empty_ofs);
            A_FULL:     next_rdata = REG_W'(full_ofs);
            A_STATUS:   next_rdata = REG_W'(status);
            A_RB_EMPTY: next_rdata = REG_W'(rbuf[OFS_W-1:0]);
            A_RB_FULL:  next_rdata = REG_W'(rbuf[RW*OUT_W +: OFS_W]);
            default:    next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cfg       <= CFG_RESET;
         empty_ofs <= '0;
         full_ofs  <= '0;
         rdata     <= '0;
      end else begin
         cfg       <= next_cfg;
         empty_ofs <= next_empty;
         full_ofs  <= next_full;
         rdata     <= next_rdata;
      end
   end

   // edge counters watched by the checks below
   always_comb begin
      next_nsclk = (st == S_IDLE) ? '0 : nsclk +
         6'(next_pins.serial_clock & ~pins.serial_clock);
      next_nwclk = (st == S_IDLE) ? '0 : nwclk +
         6'(next_pins.write_clock & ~pins.write_clock &
            ~next_pins.write_enable_n);
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         nsclk <= '0;
         nwclk <= '0;
      end else begin
         nsclk <= next_nsclk;
         nwclk <= next_nwclk;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence shift_done;
      st == S_SHIFT ##1 st == S_SETTLE;
   endsequence
   sequence write_done;
      st == S_WRITE ##1 st == S_SETTLE;
   endsequence

   a_gap_reads: assert property ($rose(pins.read_enable_n) |->
      pins.read_enable_n [*8]) else $error("offset reads too close");
   a_shift_enables: assert property ($rose(pins.serial_clock) |->
      !pins.load_select_n && !pins.serial_enable_n)
      else $error("serial edge without enables");
   a_shift_length: assert property (shift_done |->
      nsclk == 6'(2 * OFS_W)) else $error("wrong serial length");
   a_shift_no_write: assert property (!pins.serial_enable_n |->
      pins.write_enable_n) else $error("write during shifting");
   a_write_count: assert property (write_done |->
      nwclk == 6'(2 * WW)) else $error("wrong offset write count");
   a_no_rw_same: assert property (!(!pins.write_enable_n &&
      !pins.read_enable_n)) else $error("offset read and write");
   a_write_ld: assert property ($rose(pins.write_clock) &&
      !pins.write_enable_n |-> !pins.load_select_n && pins.mrs_n)
      else $error("offset write without load select");
   a_read_ld: assert property ($rose(pins.read_clock) &&
      !pins.read_enable_n |-> !pins.load_select_n && st == S_READ)
      else $error("offset read without load select");
   a_serial_settle: assert property (shift_done |->
      ##23 (st == S_SETTLE && !valid) ##1 valid)
      else $error("serial flag wait wrong");
   a_par_settle: assert property (write_done |->
      ##15 (st == S_SETTLE && !valid) ##1 valid)
      else $error("parallel flag wait wrong");
   a_settle_invalid: assert property (st == S_SETTLE |-> !valid)
      else $error("flags valid while settling");
   a_mode_hold: assert property ($changed(pins.serial_mode) |->
      !pins.mrs_n) else $error("mode moved outside reset");
endmodule : fifo_offset_host

// ===== rtl/fofs_pkg.sv
package fofs_pkg;
   // command port layout
   localparam int         ADDR_W      = 8;
   localparam int         REG_W       = 32;
   localparam logic [7:0] A_CTRL      = 8'h00;
   localparam logic [7:0] A_CFG       = 8'h04;
   localparam logic [7:0] A_EMPTY     = 8'h08;
   localparam logic [7:0] A_FULL      = 8'h0C;
   localparam logic [7:0] A_STATUS    = 8'h10;
   localparam logic [7:0] A_RB_EMPTY  = 8'h14;
   localparam logic [7:0] A_RB_FULL   = 8'h18;
   localparam int         CTRL_GO     = 0;
   localparam int         CTRL_CMD    = 1;
   localparam int         CFG_SERIAL  = 0;
   localparam int         CFG_FIRST_WORD_FALL_THROUGH    = 1;
   localparam logic [1:0] CFG_RESET   = 2'h1;
   localparam int         ST_BUSY     = 0;
   localparam int         ST_SERIAL   = 1;
   localparam int         ST_MRS_DONE = 2;
   localparam int         ST_VALID    = 3;
   localparam int         ST_AE       = 4;
   localparam int         ST_AF       = 5;
   // link timing
   localparam int MCLK_PERIOD_NS = 20;
   localparam int LINK_PERIOD_NS = 160;
   localparam int LINK_HALF      = LINK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
   localparam int PH_W           = $clog2(2 * LINK_HALF);
   localparam int MRS_STEPS      = 2;
   localparam int SETTLE_SER     = 3;
   localparam int SETTLE_PAR     = 2;

   typedef enum logic [1:0] {
      CMD_MRESET   = 2'h0,
      CMD_SERIAL   = 2'h1,
      CMD_PARALLEL = 2'h2,
      CMD_READ     = 2'h3
   } cmd_t;

   typedef enum logic [2:0] {
      S_IDLE   = 3'h0,
      S_SHIFT  = 3'h1,
      S_SETTLE = 3'h3,
      S_WRITE  = 3'h2,
      S_READ   = 3'h6,
      S_RESET  = 3'h4
   } state_t;

   typedef struct packed {
      logic mrs_n;
      logic serial_mode;
      logic first_word_fall_through;
      logic load_select_n;
      logic write_enable_n;
      logic read_enable_n;
      logic serial_enable_n;
      logic serial_clock;
      logic serial_in;
      logic write_clock;
      logic read_clock;
   } pins_t;

   localparam pins_t PINS_IDLE = '{mrs_n: 1'h1, serial_mode: 1'h1,
      first_word_fall_through: 1'h0, load_select_n: 1'h1,
      write_enable_n: 1'h1, read_enable_n: 1'h1, serial_enable_n: 1'h1,
      serial_clock: 1'h0, serial_in: 1'h0, write_clock: 1'h0,
      read_clock: 1'h0};

   function automatic int words_per_offset(input int bus_w,
                                           input int ofs_w);
      if (bus_w >= 36) return 1;
      if (bus_w >= 18) return (ofs_w > 16) ? 2 : 1;
      return (ofs_w > 16) ? 3 : 2;
   endfunction : words_per_offset
endpackage : fofs_pkg

// ===== testbench/fifo_offset_dev.sv
`timescale 1ns/100ps
module fifo_offset_dev #(
   parameter int BUS_W = 18,
   parameter int OUT_W = 18,
   parameter int OFS_W = 18
) (
   // fifo pins
   input  fofs_pkg::pins_t          pins,
   input  wire logic [BUS_W-1:0]    write_data_in,
   output logic      [OUT_W-1:0]    read_data_out,
   output logic                     almost_empty_flag_n,
   output logic                     almost_full_flag_n,
   // pin protocol breach seen
   output logic                     viol
);
   import fofs_pkg::*;
   localparam int WW = (BUS_W >= 36) ? 1 : (BUS_W >= 18) ?
                       ((OFS_W > 16) ? 2 : 1) : ((OFS_W > 16) ? 3 : 2);
   localparam int RW = (OUT_W >= 36) ? 1 : (OUT_W >= 18) ?
                       ((OFS_W > 16) ? 2 : 1) : ((OFS_W > 16) ? 3 : 2);
   localparam int SL = 2 * OFS_W;
   logic             smode;
   logic [OFS_W-1:0] ofs [2];
   int               spos, wptr, rptr, aec, afc, need;
   logic             ser_done, par_done, done, last_rd, rd_now;
   logic [WW*BUS_W-1:0] wext;
   logic [RW*OUT_W-1:0] rext;

   initial begin
      viol = 1'h0;
      read_data_out = '1;
   end
   // mode pins only count while master reset is low; first_word_fall_through is ignored
   always @(pins.mrs_n or pins.serial_mode) begin
      if (!pins.mrs_n) smode = pins.serial_mode;
   end
   always @(posedge pins.serial_clock or negedge pins.mrs_n) begin
      if (!pins.mrs_n) begin
         spos <= 0;
         ser_done <= 1'h0;
      end else if (smode && !pins.load_select_n &&
                   !pins.serial_enable_n) begin
         if (spos < OFS_W) ofs[0][spos] <= pins.serial_in;
         else ofs[1][spos-OFS_W] <= pins.serial_in;
         ser_done <= (spos == SL - 1);
         spos <= (spos == SL - 1) ? 0 : spos + 1;
      end
   end
   always @(posedge pins.write_clock or negedge pins.mrs_n) begin
      if (!pins.mrs_n) begin
         wptr <= 0;
         par_done <= 1'h0;
         ofs[0] <= '0;
         ofs[1] <= '0;
      end else if (!smode && !pins.load_select_n &&
                   !pins.write_enable_n) begin
         wext = ofs[wptr / WW];
         wext[(wptr % WW) * BUS_W +: BUS_W] = write_data_in;
         ofs[wptr / WW] <= wext[OFS_W-1:0];
         par_done <= (wptr == 2 * WW - 1);
         wptr <= (wptr == 2 * WW - 1) ? 0 : wptr + 1;
      end
   end
   always @(posedge pins.read_clock or negedge pins.mrs_n) begin
      if (!pins.mrs_n) begin
         rptr <= 0;
         last_rd <= 1'h0;
      end else begin
         rd_now = !pins.load_select_n && !pins.read_enable_n;
         if (rd_now && (last_rd || !pins.write_enable_n)) viol <= 1'h1;
         last_rd <= rd_now;
         if (rd_now) begin
            rext = ofs[rptr / RW];
            read_data_out <= rext[(rptr % RW) * OUT_W +: OUT_W];
            rptr <= (rptr == 2 * RW - 1) ? 0 : rptr + 1;
         end
      end
   end
   // flags count settle edges from the edge that completes the set
   assign done = ser_done | par_done;
   assign need = smode ? 3 : 2;
   always @(posedge pins.write_clock or negedge done) begin
      if (!done) afc <= 0;
      else if (afc < 3) afc <= afc + 1;
   end
   always @(posedge pins.read_clock or negedge done) begin
      if (!done) aec <= 0;
      else if (aec < 3) aec <= aec + 1;
   end
   assign almost_full_flag_n  = !(done && afc >= need);
   assign almost_empty_flag_n = !(done && aec >= need);
endmodule : fifo_offset_dev

// ===== testbench/test_fifo_offset_host.sv
`timescale 1ns/100ps
module test_fifo_offset_host;
   import fofs_pkg::*;
   localparam int BW = 18;
   localparam int OW = 18;
   localparam int FW = 18;
   logic              mclk, rst, wr_en, rd_en, ae_n, af_n, viol, sm, fw;
   logic [ADDR_W-1:0] addr;
   logic [REG_W-1:0]  wdata, rdata, got;
   pins_t             pins;
   logic [BW-1:0]     wdi;
   logic [OW-1:0]     rdo;
   logic [FW-1:0]     eo, fo;
   int                num_errors, comparisons;

   fifo_offset_host #(.BUS_W(BW), .OUT_W(OW), .OFS_W(FW)) uut (
      .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .pins(pins), .write_data_in(wdi),
      .read_data_out(rdo), .almost_empty_flag_n(ae_n),
      .almost_full_flag_n(af_n));
   fifo_offset_dev #(.BUS_W(BW), .OUT_W(OW), .OFS_W(FW)) dev (
      .pins(pins), .write_data_in(wdi), .read_data_out(rdo),
      .almost_empty_flag_n(ae_n), .almost_full_flag_n(af_n), .viol(viol));

   always #10 mclk = ~mclk;

   task automatic finish_test;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input logic [REG_W-1:0] g, input logic [REG_W-1:0] e);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch at %0t got %0h expected %0h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [REG_W-1:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'h1;
      @(posedge mclk);
      wr_en <= 1'h0;
   endtask : wr
   // read data is taken just after the edge that answers the strobe
   task automatic rd(input logic [7:0] a, output logic [REG_W-1:0] d);
      @(posedge mclk);
      addr <= a;
      rd_en <= 1'h1;
      @(posedge mclk);
      rd_en <= 1'h0;
      #1 d = rdata;
   endtask : rd
   task automatic go(input cmd_t c);
      wr(A_CTRL, (REG_W'(c) << CTRL_CMD) | 32'h1);
   endtask : go
   task automatic wait_idle;
      int n;
      n = 0;
      got = 32'h1;
      while (got[ST_BUSY] !== 1'h0) begin
         rd(A_STATUS, got);
         n++;
         if (n > 2000) begin
            chk(got, 32'h0);
            finish_test();
         end
      end
   endtask : wait_idle

   initial begin
      mclk = 1'h0;
      rst = 1'h1;
      addr = '0;
      wdata = '0;
      wr_en = 1'h0;
      rd_en = 1'h0;
      num_errors = 0;
      comparisons = 0;
      void'($urandom(47));
      repeat (8) @(posedge mclk);
      rst <= 1'h0;
      rd(A_CFG, got);
      chk(got, 32'(CFG_RESET));
      @(posedge mclk);
      #1 chk(rdata, 32'h0);
      rd(8'hFC, got);
      chk(got, 32'h0);
      for (int m = 0; m < 4; m++) begin
         sm = (m % 2 == 0);
         fw = (m / 2 == 1);
         eo = (m == 0) ? '0 : (m == 1) ? '1 : FW'($urandom);
         fo = (m == 0) ? '1 : (m == 1) ? '0 : FW'($urandom);
         wr(A_CFG, {30'h0, fw, sm});
         go(CMD_MRESET);
         wait_idle();
         chk(got[ST_SERIAL], sm);
         chk(got[ST_VALID], 32'h0);
         chk(dev.wptr + dev.rptr + dev.spos, 32'h0);
         wr(A_EMPTY, 32'(eo));
         wr(A_FULL, 32'(fo));
         go(sm ? CMD_PARALLEL : CMD_SERIAL);
         rd(A_STATUS, got);
         chk(got[ST_BUSY], 32'h0);
         go(sm ? CMD_SERIAL : CMD_PARALLEL);
         wait_idle();
         chk(dev.ofs[0], eo);
         chk(dev.ofs[1], fo);
         chk(got[ST_AF:ST_VALID], 32'h7);
         for (int r = 0; r < 2; r++) begin
            go(CMD_READ);
            wait_idle();
            rd(A_RB_EMPTY, got);
            chk(got, 32'(eo));
            rd(A_RB_FULL, got);
            chk(got, 32'(fo));
         end
      end
      chk(viol, 32'h0);
      rst <= 1'h1;
      repeat (2) @(posedge mclk);
      rst <= 1'h0;
      #1 chk(pins, 32'(PINS_IDLE));
      finish_test();
   end
endmodule : test_fifo_offset_host
